// >>> rtl/coalesce_pkg.sv
package coalesce_pkg;

    // Register word offsets on the plain register port (byte addresses).
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET   = 8'h08;
    localparam logic [7:0] COUNT_OFFSET  = 8'h0C;

    // Control word field positions.
    localparam int DLY_EN_BIT   = 13;
    localparam int ERR_EN_BIT   = 14;
    localparam int RSVD_BIT     = 15;
    localparam int THRESH_LSB   = 16;
    localparam int THRESH_MSB   = 23;
    localparam int DELAY_LSB    = 24;
    localparam int DELAY_MSB    = 31;

    // Status and mask share one layout.
    localparam int CMPL_BIT     = 0;
    localparam int DLYIRQ_BIT   = 1;
    localparam int ERRIRQ_BIT   = 2;
    localparam int EVENT_BITS   = 3;

    // Values after reset.
    localparam logic [7:0] THRESH_RESET = 8'h01;
    localparam logic [7:0] DELAY_RESET  = 8'h00;
    localparam logic [2:0] MASK_RESET   = 3'h7;
    localparam logic       DLY_EN_RESET = 1'b0;
    localparam logic       ERR_EN_RESET = 1'b0;

    // Default clock cycles per delay timer unit.
    localparam int TICK_CYCLES_DEFAULT = 1000;

    // Delay timer states.
    typedef enum logic [0:0] {
        TIMER_IDLE,
        TIMER_RUN
    } timer_state_type;

endpackage : coalesce_pkg

// >>> rtl/delay_tick.sv
// Prescaler that turns the system clock into delay timer units.
module delay_tick #(
    parameter int TICK_CYCLES = 1000
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Control.
    input  wire logic run,
    input  wire logic restart,
    // Unit pulse.
    output logic      tick
);

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } tick_state_type;

    tick_state_type state;
    tick_state_type next_state;

    // Count up while running; a restart aligns the unit boundary to the event.
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (restart || !run) begin
            next_state.count = 32'h0;
        end else if (state.count == 32'(TICK_CYCLES - 1)) begin
            next_state.count = 32'h0;
            next_state.tick  = 1'b1;
        end else begin
            next_state.count = state.count + 32'h1;
        end
    end

    // State register.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule : delay_tick

// >>> rtl/stream_to_memory_irq_coalescer.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module stream_to_memory_irq_coalescer #(
    parameter bit descriptor_mode_select = 1'b1,
    parameter int TICK_CYCLES            = coalesce_pkg::TICK_CYCLES_DEFAULT
) (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Channel events, one-cycle pulses.
    input  wire logic        completion_event,
    input  wire logic        packet_start,
    input  wire logic        packet_end,
    input  wire logic        error_event,
    // Interrupt to the processor.
    output logic             irq
);

    // All state of the block.
    typedef struct packed {
        logic                                    delay_enable;
        logic                                    error_interrupt_enable;
        logic [7:0]                              threshold;
        logic [7:0]                              delay;
        logic [coalesce_pkg::EVENT_BITS-1:0]     status;
        logic [coalesce_pkg::EVENT_BITS-1:0]     mask;
        logic [7:0]                              count;
        coalesce_pkg::timer_state_type           timer_state;
        logic [7:0]                              timer_units;
        logic [31:0]                             rdata;
        logic                                    irq;
    } coalesce_state_type;

    coalesce_state_type state;
    coalesce_state_type next_state;

    logic tick;
    logic timer_restart;

    // Decode of one register offset against the bus address.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction : hit

    // Control word as software sees it; the reserved bit always reads zero.
    function automatic logic [31:0] ctrl_word(input coalesce_state_type s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[coalesce_pkg::DLY_EN_BIT] = s.delay_enable;
        w[coalesce_pkg::ERR_EN_BIT] = s.error_interrupt_enable;
        w[coalesce_pkg::RSVD_BIT]   = 1'b0;
        w[coalesce_pkg::THRESH_MSB:coalesce_pkg::THRESH_LSB] = s.threshold;
        w[coalesce_pkg::DELAY_MSB:coalesce_pkg::DELAY_LSB]   = s.delay;
        return w;
    endfunction : ctrl_word

    // The prescaler only runs while a delay period is being timed.
    assign timer_restart = packet_start || packet_end;

    delay_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .run     (state.timer_state == coalesce_pkg::TIMER_RUN),
        .restart (timer_restart),
        .tick    (tick)
    );

    // Next-state logic for registers, counter, timer and interrupt.
    always_comb begin
        logic                                threshold_hit;
        logic                                delay_expired;
        logic                                delay_allowed;
        logic                                ctrl_wr;
        logic [7:0]                          new_threshold;
        logic [coalesce_pkg::EVENT_BITS-1:0] set_bits;
        logic [coalesce_pkg::EVENT_BITS-1:0] clear_bits;

        threshold_hit = 1'b0;
        delay_expired = 1'b0;
        delay_allowed = 1'b0;
        ctrl_wr       = reg_write && hit(reg_addr, coalesce_pkg::CTRL_OFFSET);
        new_threshold = reg_wdata[coalesce_pkg::THRESH_MSB:coalesce_pkg::THRESH_LSB];
        set_bits      = '0;
        clear_bits    = '0;
        next_state    = state;

        // Control register write. The reserved bit has no storage at all.
        if (ctrl_wr) begin
            next_state.delay_enable           = reg_wdata[coalesce_pkg::DLY_EN_BIT];
            next_state.error_interrupt_enable = reg_wdata[coalesce_pkg::ERR_EN_BIT];
            next_state.delay = reg_wdata[coalesce_pkg::DELAY_MSB:coalesce_pkg::DELAY_LSB];
            if (new_threshold != 8'h00) begin
                next_state.threshold = new_threshold;
            end
        end

        // Mask register write.
        if (reg_write && hit(reg_addr, coalesce_pkg::MASK_OFFSET)) begin
            next_state.mask = reg_wdata[coalesce_pkg::EVENT_BITS-1:0];
        end

        // Threshold counter. In simple mode every completion interrupts at once,
        // since the threshold field is ignored there.
        if (!descriptor_mode_select) begin
            next_state.count = 8'h01;
            threshold_hit    = completion_event;
        end else if (ctrl_wr && new_threshold != 8'h00) begin
            // A new threshold restarts coalescing so the old count cannot linger.
            next_state.count = new_threshold;
            if (completion_event && new_threshold == 8'h01) begin
                threshold_hit = 1'b1;
            end else if (completion_event) begin
                next_state.count = new_threshold - 8'h01;
            end
        end else if (completion_event) begin
            if (state.count <= 8'h01) begin
                threshold_hit    = 1'b1;
                next_state.count = next_state.threshold;
            end else begin
                next_state.count = state.count - 8'h01;
            end
        end

        // Delay timer. A new packet stops it, the end of a packet starts it
        // afresh, and a timeout returns it to idle until the next packet end.
        unique case (state.timer_state)
            coalesce_pkg::TIMER_IDLE: begin
                next_state.timer_units = 8'h00;
                if (packet_end && !packet_start) begin
                    next_state.timer_state = coalesce_pkg::TIMER_RUN;
                end
            end
            coalesce_pkg::TIMER_RUN: begin
                if (packet_start) begin
                    next_state.timer_state = coalesce_pkg::TIMER_IDLE;
                    next_state.timer_units = 8'h00;
                end else if (packet_end) begin
                    next_state.timer_units = 8'h00;
                end else if (state.delay == 8'h00) begin
                    // A zero period never expires; the timer simply waits.
                    next_state.timer_units = 8'h00;
                end else if (tick) begin
                    if (state.timer_units + 8'h01 >= state.delay) begin
                        delay_expired          = 1'b1;
                        next_state.timer_state = coalesce_pkg::TIMER_IDLE;
                        next_state.timer_units = 8'h00;
                    end else begin
                        next_state.timer_units = state.timer_units + 8'h01;
                    end
                end
            end
        endcase

        // Delay events count only with the enable set and in descriptor mode,
        // where the enable bit is honoured at all.
        delay_allowed = descriptor_mode_select && state.delay_enable;

        // Sticky status: hardware sets, software clears by writing ones.
        set_bits[coalesce_pkg::CMPL_BIT]   = threshold_hit;
        set_bits[coalesce_pkg::DLYIRQ_BIT] = delay_expired && delay_allowed;
        set_bits[coalesce_pkg::ERRIRQ_BIT] = error_event
                                             && state.error_interrupt_enable;
        if (reg_write && hit(reg_addr, coalesce_pkg::STATUS_OFFSET)) begin
            clear_bits = reg_wdata[coalesce_pkg::EVENT_BITS-1:0];
        end
        // Set wins over clear so an event in the clearing cycle is not lost.
        next_state.status = (state.status & ~clear_bits) | set_bits;

        // Level interrupt from the next status and mask, so it changes in the same cycle as they do.
        next_state.irq = |(next_state.status & next_state.mask);

        // Read data stand for exactly one cycle after the read strobe.
        next_state.rdata = 32'h0000_0000;
        if (reg_read) begin
            if (hit(reg_addr, coalesce_pkg::CTRL_OFFSET)) begin
                next_state.rdata = ctrl_word(state);
            end else if (hit(reg_addr, coalesce_pkg::STATUS_OFFSET)) begin
                next_state.rdata = {29'h0, state.status};
            end else if (hit(reg_addr, coalesce_pkg::MASK_OFFSET)) begin
                next_state.rdata = {29'h0, state.mask};
            end else if (hit(reg_addr, coalesce_pkg::COUNT_OFFSET)) begin
                next_state.rdata = {16'h0, state.timer_units, state.count};
            end
        end
    end

    // State register; all control state has a constant value after reset.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state.delay_enable           <= coalesce_pkg::DLY_EN_RESET;
            state.error_interrupt_enable <= coalesce_pkg::ERR_EN_RESET;
            state.threshold              <= coalesce_pkg::THRESH_RESET;
            state.delay                  <= coalesce_pkg::DELAY_RESET;
            state.status                 <= '0;
            state.mask                   <= coalesce_pkg::MASK_RESET;
            state.count                  <= coalesce_pkg::THRESH_RESET;
            state.timer_state            <= coalesce_pkg::TIMER_IDLE;
            state.timer_units            <= 8'h00;
            state.rdata                  <= 32'h0000_0000;
            state.irq                    <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign reg_rdata = state.rdata;
    assign irq       = state.irq;

endmodule : stream_to_memory_irq_coalescer

// >>> verification/coalesce_monitor.sv
module coalesce_monitor #(
    parameter bit descriptor_mode_select = 1'b1
) (
    // Clock and reset.
    input logic        sys_clk,
    input logic        nrst,
    // Register port.
    input logic [7:0]  reg_addr,
    input logic [31:0] reg_wdata,
    input logic        reg_write,
    input logic        reg_read,
    input logic [31:0] reg_rdata,
    // Events and interrupt.
    input logic        completion_event,
    input logic        packet_start,
    input logic        packet_end,
    input logic        error_event,
    input logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] thr_q;
    logic [7:0] dly_q;
    logic [2:0] msk_q;
    logic       den_q;
    logic       een_q;
    logic       ctl_rd;
    logic       cause;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Shadow settings, kept from the writes so no internal view is needed.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {dly_q, thr_q, een_q, den_q, msk_q} <= {8'h00, 8'h01, 2'h0, 3'h7};
        end else if (reg_write && reg_addr == coalesce_pkg::CTRL_OFFSET) begin
            dly_q <= reg_wdata[31:24];
            {een_q, den_q} <= reg_wdata[14:13];
            if (reg_wdata[23:16] != 8'h00) thr_q <= reg_wdata[23:16];
        end else if (reg_write && reg_addr == coalesce_pkg::MASK_OFFSET) begin
            msk_q <= reg_wdata[2:0];
        end
    end
    // Simple mode may drop the stored fields, so field reads are judged in full mode only.
    assign ctl_rd = descriptor_mode_select && reg_read && reg_addr == coalesce_pkg::CTRL_OFFSET;
    assign cause = completion_event || error_event ||
                   (reg_write && reg_addr == coalesce_pkg::MASK_OFFSET);
    chk_rsvd_zero: assert property ($past(ctl_rd) |->
        reg_rdata[15:0] == {1'h0, reg_rdata[14:13], 13'h0000})
        else $error("reserved control bits read nonzero");
    chk_thresh_kept: assert property ($past(ctl_rd) |->
        reg_rdata[23:16] == $past(thr_q))
        else $error("threshold field read back wrong");
    chk_delay_field: assert property ($past(ctl_rd) |->
        reg_rdata[31:24] == $past(dly_q))
        else $error("delay field read back wrong");
    chk_enable_bits: assert property ($past(ctl_rd) |->
        reg_rdata[14:13] == {$past(een_q), $past(den_q)})
        else $error("enable bits read back wrong");
    chk_err_raise: assert property (error_event && een_q && msk_q[2] |=> irq)
        else $error("enabled error did not raise irq");
    chk_cmpl_at_one: assert property (completion_event && thr_q == 8'h01 &&
        msk_q[0] && !reg_write |=> irq)
        else $error("completion at threshold one did not raise irq");
    chk_dly_off_quiet: assert property ($rose(irq) && !den_q && !$past(den_q) |->
        $past(cause) || $past(cause, 2))
        else $error("irq rose without cause while delay disabled");
    chk_zero_delay_quiet: assert property ($rose(irq) && dly_q == 8'h00 &&
        $past(dly_q) == 8'h00 |-> $past(cause) || $past(cause, 2))
        else $error("irq rose without cause while delay is zero");
    cov_irq_rise: cover property ($rose(irq));
    cov_dly_raise: cover property ($rose(irq) && den_q && dly_q != 8'h00);
    cov_err_taken: cover property (error_event && een_q);
    cov_ctrl_read: cover property ($past(ctl_rd));
endmodule : coalesce_monitor

bind stream_to_memory_irq_coalescer coalesce_monitor #(
    .descriptor_mode_select(descriptor_mode_select)
) u_mon (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
         .completion_event, .packet_start, .packet_end, .error_event, .irq);

// >>> verification/irq_sink.sv
module irq_sink (
    // Clock and reset.
    input  logic sys_clk,
    input  logic nrst,
    // Interrupt line and count of interrupts taken.
    input  logic irq,
    output int   taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_d;
    // A level line is taken once per rise, so a held line is not counted twice.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_d <= 1'h0;
            taken <= 0;
        end else begin
            irq_d <= irq;
            if (irq && !irq_d) taken <= taken + 1;
        end
    end
endmodule : irq_sink

// >>> verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] thr; logic [3:0] n; logic irq; logic [7:0] cnt;} row_type;
    localparam row_type ROWS [4] = '{'{8'h03, 4'h2, 1'h0, 8'h01}, '{8'h03, 4'h3, 1'h1, 8'h03},
                                     '{8'h01, 4'h1, 1'h1, 8'h01}, '{8'h02, 4'h1, 1'h0, 8'h01}};
    localparam logic [7:0] CNT  = coalesce_pkg::COUNT_OFFSET;
    localparam logic [7:0] CTRL = coalesce_pkg::CTRL_OFFSET;
    localparam logic [7:0] STAT = coalesce_pkg::STATUS_OFFSET;
    localparam logic [7:0] MASK = coalesce_pkg::MASK_OFFSET;
    logic        sys_clk = 1'h0;
    logic        nrst = 1'h0;
    logic        reg_write = 1'h0;
    logic        reg_read = 1'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [3:0]  ev = 4'h0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_val;
    logic        irq;
    logic        s_irq;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          taken;
    // Full mode and simple mode see the same stimulus side by side.
    stream_to_memory_irq_coalescer #(.TICK_CYCLES(4)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .completion_event(ev[0]), .packet_start(ev[1]),
        .packet_end(ev[2]), .error_event(ev[3]), .irq(irq));
    stream_to_memory_irq_coalescer #(.descriptor_mode_select(1'b0), .TICK_CYCLES(4)) u_simple (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(), .completion_event(ev[0]),
        .packet_start(ev[1]), .packet_end(ev[2]), .error_event(ev[3]), .irq(s_irq));
    irq_sink u_sink (.sys_clk(sys_clk), .nrst(nrst), .irq(irq), .taken(taken));
    always #5 sys_clk = ~sys_clk;
    // A hung wait is cut short well beyond the few hundred cycles the tests need.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge sys_clk);
        reg_write <= 1'h0;
    endtask : wr
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge sys_clk);
        reg_read <= 1'h0;
        #1 chk(reg_rdata, exp);
    endtask : rdchk
    // One-cycle event pulse; returns once the edge that took it has settled.
    task pulse(input logic [3:0] m);
        @(posedge sys_clk);
        ev <= m;
        @(posedge sys_clk);
        ev <= 4'h0;
        #1;
    endtask : pulse
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task results;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'h1;
        rdchk(CTRL, 32'h0001_0000);
        rdchk(MASK, 32'h7);
        rdchk(8'h10, 32'h0);
        wr(CTRL, 32'h0500_FFFF);
        rdchk(CTRL, 32'h0501_6000);
        $display("test reset_and_fields done");
        foreach (ROWS[i]) begin
            wr(CTRL, {8'h00, ROWS[i].thr, 16'h0000});
            repeat (ROWS[i].n) pulse(4'h1);
            chk(32'(irq), 32'(ROWS[i].irq));
            chk(32'(s_irq), 32'h1);
            rdchk(STAT, 32'(ROWS[i].irq));
            rdchk(CNT, {16'h0000, 8'h00, ROWS[i].cnt});
            wr(STAT, 32'h7);
        end
        $display("test threshold_rows done");
        pulse(4'h8);
        chk(32'(irq), 32'h0);
        wr(CTRL, 32'h0001_4000);
        pulse(4'h8);
        rdchk(STAT, 32'h4);
        wr(STAT, 32'h7);
        wr(MASK, 32'h3);
        pulse(4'h8);
        chk(32'(irq), 32'h0);
        wr(MASK, 32'h7);
        tick(1);
        chk(32'(irq), 32'h1);
        wr(STAT, 32'h7);
        $display("test error_and_mask done");
        wr(CTRL, 32'h0201_2000);
        pulse(4'h4);
        for (int i = 0; i < 30 && irq !== 1'h1; i++) tick(1);
        chk(32'(irq), 32'h1);
        chk(32'(s_irq), 32'h0);
        rdchk(STAT, 32'h2);
        wr(STAT, 32'h7);
        tick(30);
        chk(32'(irq), 32'h0);
        pulse(4'h4);
        pulse(4'h2);
        tick(30);
        chk(32'(irq), 32'h0);
        wr(CTRL, 32'h0201_0000);
        pulse(4'h4);
        tick(30);
        chk(32'(irq), 32'h0);
        wr(CTRL, 32'h0001_2000);
        pulse(4'h4);
        tick(30);
        chk(32'(irq), 32'h0);
        chk(32'(taken), 32'h5);
        $display("test delay_timer done");
        // A reset in mid-run must drop a raised interrupt and restore every field.
        wr(CTRL, 32'h0304_4000);
        pulse(4'h8);
        chk(32'(irq), 32'h1);
        @(posedge sys_clk);
        nrst <= 1'h0;
        #1 chk(32'(irq), 32'h0);
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        #1 chk(reg_rdata, 32'h0);
        rdchk(CTRL, 32'h0001_0000);
        rdchk(MASK, 32'h7);
        rdchk(CNT, 32'h0000_0001);
        chk(32'(irq), 32'h0);
        $display("test mid_reset done");
        results();
    end
endmodule : testbench
